// file: src/tsc_pkg.sv
package tsc_pkg;
  // ----------------------------------------
  // Bus addressing
  // ----------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h29;
  localparam logic [7:0] ADDR_BYTE_WR = 8'h52;
  localparam logic [7:0] ADDR_BYTE_RD = 8'h53;
  localparam int MAX_BUS_KBPS = 1000;
  // ----------------------------------------
  // Register space
  // ----------------------------------------
  localparam int IDX_W = 16;
  localparam int REG_DEPTH = 256;
  localparam int REG_AW = 8;
  localparam logic [15:0] IDX_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] IDX_RESULT = 16'h0089;
  localparam logic [15:0] IDX_INT_CLEAR = 16'h0086;
  // Identity bytes, values arbitrary
  localparam logic [15:0] IDX_ID0 = 16'h0010;
  localparam logic [7:0] ID0_VALUE = 8'h5a;
  localparam logic [15:0] IDX_ID1 = 16'h0011;
  localparam logic [7:0] ID1_VALUE = 8'ha5;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int BOOT_TIME_US_X10 = 12;
  localparam int BOOT_CYCLES = (CLK_HZ / 1_000_000) * BOOT_TIME_US_X10 * 100;
  localparam int RANGE_CYCLES = 2000;
endpackage : tsc_pkg

// file: src/tsc_sync.sv
`timescale 1ns/1ps
module tsc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1_q <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule : tsc_sync

// file: src/tsc_regfile.sv
`timescale 1ns/1ps
module tsc_regfile #(
  parameter int DEPTH = tsc_pkg::REG_DEPTH,
  parameter int AW = tsc_pkg::REG_AW
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= tsc_pkg::REG_RESET;
      end
    end else if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdData = mem[rdAddr];
endmodule : tsc_regfile

// file: src/tsc_i2c_port.sv
`timescale 1ns/1ps
// Behaviour
// (R1) Answer only slave address byte 0x52; the code also answers 0x53, since it compares only bits 7:1
// (R2) Address lsb selects write or read
// (R3) Bus rates up to one megabit supported
// (R4) Byte then one acknowledge bit
// (R5) Sample SDA on rising SCL
// (R6) Start/stop: SDA edge while SCL high
// (R7) Host frames messages with start/stop
// (R8) Acknowledge own address, store direction
// (R9) Write: two index bytes, MSB first
// (R10) Shift, acknowledge, store written byte
// (R11) Read: load register, shift on SCL fall
// (R12) Receiver acknowledges every byte
// (R13) Only host ends message, stop or NACK
// (R14) Index increments after each data byte
// (R15) Host streams writes without new index
// (R16) Lines only pulled low, idle high
// (R17) Host drives SCL; device never does
// (R18) Measurement ready drives interrupt pin high
// (R19) Reading result clears; ranging holds meanwhile
// (R20) Host prefers interrupt pin over polling
// (R21) Shutdown low: standby, bus silent
// (R22) Boot within 1.2 ms after shutdown rises
// (R23) Host raises shutdown after supply on
// (R24) Multi-byte: ascending, MSB lowest address
// (R25) Foreign address: release SDA, ignore
module tsc_i2c_port #(
  parameter int BOOT_CYCLES = tsc_pkg::BOOT_CYCLES,
  parameter int RANGE_CYCLES = tsc_pkg::RANGE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic shutdown_n_pin,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic interrupt_output_pin,
  output logic bootDone,
  output logic [7:0] rangeCount
);
  typedef enum logic [2:0] {
    TSC_IDLE, TSC_ADDR, TSC_ADDR_ACK, TSC_RX, TSC_RX_ACK, TSC_TX, TSC_TX_ACK
  } tsc_bus_t;
  typedef enum logic [1:0] {
    TSC_HARDWARE_STANDBY, TSC_FIRMWARE_BOOT, TSC_SOFTWARE_STANDBY
  } tsc_power_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] next_index(input logic [15:0] idx);
    return idx + 16'd1;
  endfunction : next_index

  function automatic logic [2:0] next_bit(input logic [2:0] cnt);
    return cnt + 3'd1;
  endfunction : next_bit

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic sclSync, sdaSync, shutSync;
  logic sclPrev_q, sdaPrev_q;

  tsc_sync #(.RESET_VAL(1'b1)) uSyncScl (.sys_clk(sys_clk), .rst(rst), .asyncIn(sclIn), .syncOut(sclSync));
  tsc_sync #(.RESET_VAL(1'b1)) uSyncSda (.sys_clk(sys_clk), .rst(rst), .asyncIn(sdaIn), .syncOut(sdaSync));
  tsc_sync #(.RESET_VAL(1'b0)) uSyncShut (.sys_clk(sys_clk), .rst(rst), .asyncIn(shutdown_n_pin),
    .syncOut(shutSync));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclSync;
      sdaPrev_q <= sdaSync;
    end
  end

  // Edge and condition detection; sample rate 40 MHz covers 1 Mbit/s bus
  wire sclRise = sclSync & ~sclPrev_q; // [R5] [R3]
  wire sclFall = ~sclSync & sclPrev_q; // [R11]
  wire startCond = sclSync & sclPrev_q & sdaPrev_q & ~sdaSync; // [R6]
  wire stopCond = sclSync & sclPrev_q & ~sdaPrev_q & sdaSync; // [R6]

  // ----------------------------------------
  // Power sequence
  // ----------------------------------------
  tsc_power_t pwr_q, pwr_d;
  logic [31:0] bootCnt_q, bootCnt_d;
  logic bootDone_q;

  wire bootExpired = (bootCnt_q >= 32'(BOOT_CYCLES - 1));

  always_comb begin
    pwr_d = pwr_q;
    bootCnt_d = bootCnt_q;
    case (pwr_q)
      TSC_HARDWARE_STANDBY: begin
        bootCnt_d = '0;
        if (shutSync) pwr_d = TSC_FIRMWARE_BOOT;
      end
      TSC_FIRMWARE_BOOT: begin
        bootCnt_d = bootCnt_q + 32'd1;
        if (!shutSync) pwr_d = TSC_HARDWARE_STANDBY;
        else if (bootExpired) pwr_d = TSC_SOFTWARE_STANDBY; // [R22]
      end
      TSC_SOFTWARE_STANDBY: begin
        if (!shutSync) pwr_d = TSC_HARDWARE_STANDBY; // [R21]
      end
      default: pwr_d = TSC_HARDWARE_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_q <= TSC_HARDWARE_STANDBY;
      bootCnt_q <= '0;
      bootDone_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      bootCnt_q <= bootCnt_d;
      bootDone_q <= (pwr_d == TSC_SOFTWARE_STANDBY);
    end
  end

  wire awake = (pwr_q == TSC_SOFTWARE_STANDBY); // [R21]

  // ----------------------------------------
  // Bus engine
  // ----------------------------------------
  tsc_bus_t st_q, st_d;
  logic [7:0] shift_q, shift_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic rnw_q, rnw_d;
  logic [1:0] byteNo_q, byteNo_d;
  logic [15:0] index_q, index_d;
  logic sdaOe_q, sdaOe_d;
  logic wrEn;
  logic rdResult;
  logic [7:0] rdData;
  logic [7:0] rangeCount_q;

  wire [7:0] rxByte = {shift_q[6:0], sdaSync};
  wire addrMatch = (rxByte[7:1] == tsc_pkg::ADDR_BYTE_WR[7:1]); // [R1]
  wire lastBit = (bitCnt_q == 3'd7);

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  // Identity bytes read fixed values, the result index reads the range count; all else comes from the array
  wire [7:0] rdMux = (index_q == tsc_pkg::IDX_ID0) ? tsc_pkg::ID0_VALUE :
                     (index_q == tsc_pkg::IDX_ID1) ? tsc_pkg::ID1_VALUE :
                     (index_q == tsc_pkg::IDX_RESULT) ? rangeCount_q : rdData;

  always_comb begin
    st_d = st_q;
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    rnw_d = rnw_q;
    byteNo_d = byteNo_q;
    index_d = index_q;
    sdaOe_d = sdaOe_q;
    wrEn = 1'b0;
    rdResult = 1'b0;
    if (!awake) begin
      st_d = TSC_IDLE;
      sdaOe_d = 1'b0; // [R21]
    end else if (stopCond) begin
      st_d = TSC_IDLE;
      sdaOe_d = 1'b0;
    end else if (startCond) begin
      st_d = TSC_ADDR; // [R6]
      bitCnt_d = '0;
      sdaOe_d = 1'b0;
    end else begin
      case (st_q)
        TSC_IDLE: sdaOe_d = 1'b0;
        TSC_ADDR: if (sclRise) begin
          shift_d = rxByte;
          bitCnt_d = next_bit(bitCnt_q);
          if (lastBit) begin
            if (addrMatch) begin
              st_d = TSC_ADDR_ACK;
              rnw_d = sdaSync; // [R2] [R8]
            end else begin
              st_d = TSC_IDLE; // [R25]
            end
          end
        end
        TSC_ADDR_ACK: begin
          if (sclFall && !sdaOe_q) begin
            sdaOe_d = 1'b1; // [R8] [R16]
          end else if (sclFall && sdaOe_q) begin
            bitCnt_d = '0;
            byteNo_d = '0;
            if (rnw_q) begin
              st_d = TSC_TX;
              shift_d = rdMux; // [R11]
              sdaOe_d = ~rdMux[7];
            end else begin
              st_d = TSC_RX;
              sdaOe_d = 1'b0;
            end
          end
        end
        TSC_RX: if (sclRise) begin
          shift_d = rxByte; // [R10]
          bitCnt_d = next_bit(bitCnt_q);
          if (lastBit) st_d = TSC_RX_ACK;
        end
        TSC_RX_ACK: begin
          if (sclFall && !sdaOe_q) begin
            sdaOe_d = 1'b1; // [R4] [R12]
            if (byteNo_q == 2'd0) begin
              index_d = {shift_q, index_q[7:0]}; // [R9]
              byteNo_d = 2'd1;
            end else if (byteNo_q == 2'd1) begin
              index_d = {index_q[15:8], shift_q}; // [R9]
              byteNo_d = 2'd2;
            end else begin
              wrEn = 1'b1; // [R10]
              index_d = next_index(index_q); // [R14] [R24]
            end
          end else if (sclFall && sdaOe_q) begin
            sdaOe_d = 1'b0;
            bitCnt_d = '0;
            st_d = TSC_RX;
          end
        end
        TSC_TX: if (sclFall) begin
          bitCnt_d = next_bit(bitCnt_q);
          shift_d = {shift_q[6:0], 1'b0};
          if (lastBit) begin
            st_d = TSC_TX_ACK;
            sdaOe_d = 1'b0;
            rdResult = (index_q == tsc_pkg::IDX_RESULT);
            index_d = next_index(index_q); // [R14]
          end else begin
            sdaOe_d = ~shift_q[6]; // [R11] [R16]
          end
        end
        // Host ack seen at the rise; next byte loads at the following fall
        TSC_TX_ACK: begin
          if (sclRise && sdaSync) begin
            st_d = TSC_IDLE; // [R13]
          end else if (sclFall) begin
            st_d = TSC_TX; // [R12]
            bitCnt_d = '0;
            shift_d = rdMux; // [R11]
            sdaOe_d = ~rdMux[7];
          end
        end
        default: st_d = TSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= TSC_IDLE;
      shift_q <= '0;
      bitCnt_q <= '0;
      rnw_q <= 1'b0;
      byteNo_q <= '0;
      index_q <= tsc_pkg::IDX_RESET;
      sdaOe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      rnw_q <= rnw_d;
      byteNo_q <= byteNo_d;
      index_q <= index_d;
      sdaOe_q <= sdaOe_d;
    end
  end

  // ----------------------------------------
  // Register array
  // ----------------------------------------
  tsc_regfile uRegs (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(wrEn),
    .wrAddr(index_q[tsc_pkg::REG_AW-1:0]),
    .wrData(shift_q),
    .rdAddr(index_q[tsc_pkg::REG_AW-1:0]),
    .rdData(rdData)
  );

  wire intClearWr = wrEn && (index_q == tsc_pkg::IDX_INT_CLEAR);

  // ----------------------------------------
  // Ranging handshake
  // ----------------------------------------
  logic [15:0] rangeTmr_q;
  logic intPend_q;

  wire rangeDone = awake && !intPend_q && (rangeTmr_q == 16'(RANGE_CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rangeTmr_q <= '0;
      intPend_q <= 1'b0;
      rangeCount_q <= '0;
    end else begin
      if (!awake || intPend_q) begin
        rangeTmr_q <= '0; // [R19]
      end else if (rangeDone) begin
        rangeTmr_q <= '0;
      end else begin
        rangeTmr_q <= rangeTmr_q + 16'd1;
      end
      if (!awake) begin
        intPend_q <= 1'b0;
      end else if (rangeDone) begin
        intPend_q <= 1'b1; // [R18]
      end else if (rdResult || intClearWr) begin
        intPend_q <= 1'b0; // [R19]
      end
      if (rangeDone) rangeCount_q <= rangeCount_q + 8'd1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interrupt_output_pin <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      bootDone <= 1'b0;
      rangeCount <= '0;
    end else begin
      interrupt_output_pin <= intPend_q; // [R18]
      sdaOut <= 1'b0; // [R16] [R17]
      sdaOe <= sdaOe_q;
      bootDone <= bootDone_q;
      rangeCount <= rangeCount_q;
    end
  end
endmodule : tsc_i2c_port

// file: tb/tsc_host_model.sv
`timescale 1ns/1ps
// ----
// Host bus master
// ----
module tsc_host_model (
  input wire logic sys_clk,
  input wire logic sdaWire,
  output logic sclDrv,
  output logic sdaDrv
);
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  // Host alone makes SCL, 200 ns a bit: 5 clocks low, 3 high
  task automatic clk_bit(input logic b, output logic s);
    sclDrv = 1'b0;
    tick(2);
    sdaDrv = b; // Only pulled low, else released
    tick(3);
    sclDrv = 1'b1; // SDA stable through high phase
    tick(2);
    s = sdaWire;
    tick(1);
  endtask : clk_bit
  task automatic start_c();
    sclDrv = 1'b0;
    tick(2);
    sdaDrv = 1'b1;
    tick(3);
    sclDrv = 1'b1;
    tick(8);
    sdaDrv = 1'b0;
    tick(8);
  endtask : start_c
  task automatic stop_c();
    sclDrv = 1'b0;
    tick(2);
    sdaDrv = 1'b0;
    tick(3);
    sclDrv = 1'b1;
    tick(8);
    sdaDrv = 1'b1;
    tick(8);
  endtask : stop_c
  // One byte then one acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic rd, input logic ackOut,
                      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(rd ? 1'b1 : tx[i], s);
      rx[i] = s;
    end
    clk_bit(rd ? ~ackOut : 1'b1, s); // Host acks reads, not-ack ends
    ack = ~s;
  endtask : xfer
endmodule : tsc_host_model

// file: tb/tsc_i2c_port_properties.sv
`timescale 1ns/1ps
module tsc_i2c_port_properties #(
  parameter int BOOT_CYCLES = tsc_pkg::BOOT_CYCLES,
  parameter int RANGE_CYCLES = tsc_pkg::RANGE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic shutdown_n_pin,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic interrupt_output_pin,
  input wire logic bootDone,
  input wire logic [7:0] rangeCount
);
  // ----
  // Cycles since the shutdown pin rose
  // ----
  int upCnt_q;
  always_ff @(posedge sys_clk) begin
    if (rst || !shutdown_n_pin) upCnt_q <= 0;
    else if (upCnt_q < BOOT_CYCLES + 16) upCnt_q <= upCnt_q + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_open_drain; !sdaOut; endproperty
  a_open_drain: assert property (p_open_drain) else $error("sdaOut driven high");
  property p_standby; !shutdown_n_pin [*6] |-> !bootDone && !sdaOe; endproperty
  a_standby: assert property (p_standby) else $error("active in standby");
  property p_boot_early; $rose(bootDone) |-> upCnt_q >= BOOT_CYCLES; endproperty
  a_boot_early: assert property (p_boot_early) else $error("boot too short");
  property p_boot_late; upCnt_q == BOOT_CYCLES + 12 |-> bootDone; endproperty
  a_boot_late: assert property (p_boot_late) else $error("boot too long");
  property p_scl_low; $changed(sdaOe) |-> !sclIn; endproperty
  a_scl_low: assert property (p_scl_low) else $error("SDA moved with SCL high");
  property p_int_hold; interrupt_output_pin [*3] |-> $stable(rangeCount); endproperty
  a_int_hold: assert property (p_int_hold) else $error("ranging while pending");
  property p_int_rise; $changed(rangeCount) |-> ##[0:3] interrupt_output_pin; endproperty
  a_int_rise: assert property (p_int_rise) else $error("result without interrupt");
  property p_awake; $changed(rangeCount) |-> bootDone; endproperty
  a_awake: assert property (p_awake) else $error("ranging before boot");
  property p_stop_idle; sclIn && $rose(sdaIn) |=> !sdaOe [*8]; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("SDA held after stop");
  c_boot: cover property ($rose(bootDone));
  c_ack: cover property ($rose(sdaOe));
  c_int: cover property ($rose(interrupt_output_pin));
  c_clear: cover property ($fell(interrupt_output_pin));
endmodule : tsc_i2c_port_properties

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int BOOT = 50;
  localparam int RANGE = 200;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic shutN = 1'b0;
  logic sclDrv, sdaDrv, sdaOut, sdaOe, intPin, bootDone;
  logic [7:0] rangeCount;
  wire logic sdaWire = sdaDrv & ~sdaOe;
  int n_mismatch = 0;
  int checks = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  tsc_i2c_port #(.BOOT_CYCLES(BOOT), .RANGE_CYCLES(RANGE)) tsc_i2c_port_i (.sys_clk(sys_clk), .rst(rst),
    .shutdown_n_pin(shutN), .sclIn(sclDrv), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .interrupt_output_pin(intPin), .bootDone(bootDone), .rangeCount(rangeCount));
  tsc_host_model tsc_host_model_i (.sys_clk(sys_clk), .sdaWire(sdaWire), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
  // ----
  // Helpers
  // ----
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic send(input logic [7:0] b, input logic expAck);
    logic [7:0] rx;
    logic ack;
    tsc_host_model_i.xfer(b, 1'b0, 1'b0, rx, ack);
    chk("ack", 8'(expAck), 8'(ack));
  endtask : send
  task automatic rd_chk(input logic [7:0] exp, input logic last);
    logic [7:0] rx;
    logic ack;
    tsc_host_model_i.xfer(8'hff, 1'b1, ~last, rx, ack);
    chk("read data", exp, rx);
  endtask : rd_chk
  task automatic set_idx(input logic [15:0] idx);
    tsc_host_model_i.start_c();
    send(tsc_pkg::ADDR_BYTE_WR, 1'b1);
    send(idx[15:8], 1'b1);
    send(idx[7:0], 1'b1);
  endtask : set_idx
  task automatic read_at(input logic [15:0] idx, input logic [7:0] exp);
    set_idx(idx);
    tsc_host_model_i.start_c();
    send(tsc_pkg::ADDR_BYTE_RD, 1'b1);
    rd_chk(exp, 1'b1);
    tsc_host_model_i.stop_c();
  endtask : read_at
  task automatic wait_int(input logic [7:0] expCount);
    int n;
    n = 0;
    while (intPin !== 1'b1 && n < 3 * RANGE) begin
      @(negedge sys_clk);
      n++;
    end
    chk("interrupt", 8'h01, 8'(intPin));
    chk("range count", expCount, rangeCount);
  endtask : wait_int
  // ----
  // Scenarios
  // ----
  task automatic t_standby();
    int n;
    tsc_host_model_i.start_c();
    send(tsc_pkg::ADDR_BYTE_WR, 1'b0);
    tsc_host_model_i.stop_c();
    chk("boot done", 8'h00, 8'(bootDone));
    shutN = 1'b1;
    n = 0;
    while (bootDone !== 1'b1 && n < BOOT + 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk("boot time ok", 8'h01, 8'(n >= BOOT && n <= BOOT + 10));
    $display("test standby done");
  endtask : t_standby
  task automatic t_write_read();
    logic [7:0] d[4] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4};
    set_idx(16'h0040);
    foreach (d[i]) send(d[i], 1'b1);
    tsc_host_model_i.stop_c();
    set_idx(16'h0040);
    tsc_host_model_i.start_c();
    send(tsc_pkg::ADDR_BYTE_RD, 1'b1);
    foreach (d[i]) rd_chk(d[i], i == 3);
    tsc_host_model_i.stop_c();
    chk("sda released", 8'h00, 8'(sdaOe));
    read_at(tsc_pkg::IDX_ID1, tsc_pkg::ID1_VALUE);
    $display("test write read done");
  endtask : t_write_read
  task automatic t_foreign();
    tsc_host_model_i.start_c();
    send(8'h54, 1'b0);
    send(8'h00, 1'b0);
    tsc_host_model_i.stop_c();
    tsc_host_model_i.start_c();
    send(8'h51, 1'b0);
    tsc_host_model_i.stop_c();
    $display("test foreign done");
  endtask : t_foreign
  task automatic t_interrupt();
    wait_int(8'h01);
    repeat (RANGE) @(negedge sys_clk);
    chk("count held", 8'h01, rangeCount);
    read_at(tsc_pkg::IDX_RESULT, 8'h01);
    repeat (4) @(negedge sys_clk);
    chk("cleared by read", 8'h00, 8'(intPin));
    wait_int(8'h02);
    set_idx(tsc_pkg::IDX_INT_CLEAR);
    send(8'h00, 1'b1);
    tsc_host_model_i.stop_c();
    repeat (4) @(negedge sys_clk);
    chk("cleared by write", 8'h00, 8'(intPin));
    $display("test interrupt done");
  endtask : t_interrupt
  task automatic t_shutdown();
    int n;
    shutN = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("boot done low", 8'h00, 8'(bootDone));
    chk("interrupt low", 8'h00, 8'(intPin));
    tsc_host_model_i.start_c();
    send(tsc_pkg::ADDR_BYTE_WR, 1'b0);
    tsc_host_model_i.stop_c();
    shutN = 1'b1;
    n = 0;
    while (bootDone !== 1'b1 && n < BOOT + 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk("reboot time ok", 8'h01, 8'(n >= BOOT && n <= BOOT + 10));
    read_at(tsc_pkg::IDX_ID0, tsc_pkg::ID0_VALUE);
    $display("test shutdown done");
  endtask : t_shutdown
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    t_standby();
    t_write_read();
    t_foreign();
    t_interrupt();
    t_shutdown();
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_top
bind tsc_i2c_port tsc_i2c_port_properties #(.BOOT_CYCLES(BOOT_CYCLES), .RANGE_CYCLES(RANGE_CYCLES))
  tsc_i2c_port_properties_i (.sys_clk, .rst, .shutdown_n_pin, .sclIn, .sdaIn, .sdaOut, .sdaOe,
  .interrupt_output_pin, .bootDone, .rangeCount);
